// ===== core/hsu_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes writer and reader share the clock, reset and clock enable.
`timescale 1ns/1ns
`default_nettype none
module hsu_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   // Clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Write side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Read side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic do_wr;
   logic do_rd;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("FIFO depth must be a power of two >= 2");
   end

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign do_wr = ce && in_valid && in_ready;
   assign do_rd = ce && out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (do_wr) wr_ptr <= wr_ptr + 1'b1;
         if (do_rd) rd_ptr <= rd_ptr + 1'b1;
         if (do_wr && !do_rd) count <= count + 1'b1;
         else if (do_rd && !do_wr) count <= count - 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== core/hsu_pkg.sv
// Constants for the host serial port: clock rate, bit timing and frame shape.
// Assumes a single 12 MHz system clock feeds the whole port.
package hsu_pkg;
   localparam int unsigned CLK_HZ = 12000000;
   localparam int unsigned BAUD_NOMINAL = 115200;
   // Integer division of the clock gives 104 cycles, about 8.66 us per bit.
   localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_NOMINAL;
   localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
   localparam int unsigned DATA_BITS = 8;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic START_LEVEL = 1'b0;
   localparam logic STOP_LEVEL = 1'b1;
   typedef enum logic [1:0] {HSU_RX_IDLE, HSU_RX_START, HSU_RX_DATA, HSU_RX_STOP} hsu_rx_e;
   typedef enum logic [1:0] {HSU_TX_IDLE, HSU_TX_START, HSU_TX_DATA, HSU_TX_STOP} hsu_tx_e;
endpackage

// ===== core/hsu_uart.sv
// Full-duplex asynchronous serial port toward the host, 8N1, about 115200 baud.
// Assumes a 12 MHz clock and an external line transceiver on SER_RX/SER_TX.
`timescale 1ns/1ns
`default_nettype none
module hsu_uart
   import hsu_pkg::*;
#(
   parameter int unsigned BIT_CYC = hsu_pkg::BIT_CYCLES,
   parameter int unsigned DEPTH = hsu_pkg::FIFO_DEPTH
) (
   // Clock, reset and enable
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   // Serial line
   input wire logic SER_RX,
   output logic SER_TX,
   // Transmit byte stream
   input wire logic TX_VALID,
   output logic TX_READY,
   input wire logic [7:0] TX_DATA,
   // Receive byte stream
   output logic RX_VALID,
   input wire logic RX_READY,
   output logic [7:0] RX_DATA,
   output logic RX_OVERRUN,
   output logic RX_FRAME_ERR
);
   import hsu_pkg::*;

   localparam int unsigned CW = $clog2(BIT_CYC + 1);

   initial begin
      if (BIT_CYC < 4) $error("Bit period too short");
   end

   // Receive path.
   logic rx_meta;
   logic rx_sync;
   logic rx_prev;
   hsu_rx_e rx_state;
   logic [CW-1:0] rx_cnt;
   logic [2:0] rx_bit;
   logic [7:0] rx_shift;
   logic rx_push;
   logic rx_fifo_ready;
   logic rx_tick;

   always_ff @(posedge CLK) begin
      if (RST) begin
         rx_meta <= LINE_IDLE;
         rx_sync <= LINE_IDLE;
         rx_prev <= LINE_IDLE;
      end else if (CE) begin
         rx_meta <= SER_RX;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end

   assign rx_tick = (rx_cnt == '0);

   always_ff @(posedge CLK) begin
      if (RST) begin
         rx_state <= HSU_RX_IDLE;
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_shift <= '0;
         rx_push <= 1'b0;
         RX_FRAME_ERR <= 1'b0;
      end else if (CE) begin
         rx_push <= 1'b0;
         RX_FRAME_ERR <= 1'b0;
         if (!rx_tick) rx_cnt <= rx_cnt - 1'b1;
         unique case (rx_state)
            HSU_RX_IDLE: begin
               if (rx_prev && !rx_sync) begin
                  rx_cnt <= CW'(BIT_CYC / 2 - 1);
                  rx_state <= HSU_RX_START;
               end
            end
            HSU_RX_START: begin
               if (rx_tick) begin
                  if (rx_sync != START_LEVEL) begin
                     rx_state <= HSU_RX_IDLE;
                  end else begin
                     rx_cnt <= CW'(BIT_CYC - 1);
                     rx_bit <= '0;
                     rx_state <= HSU_RX_DATA;
                  end
               end
            end
            HSU_RX_DATA: begin
               if (rx_tick) begin
                  rx_shift <= {rx_sync, rx_shift[7:1]};
                  rx_cnt <= CW'(BIT_CYC - 1);
                  rx_bit <= rx_bit + 1'b1;
                  if (rx_bit == 3'(DATA_BITS - 1)) rx_state <= HSU_RX_STOP;
               end
            end
            HSU_RX_STOP: begin
               if (rx_tick) begin
                  if (rx_sync == STOP_LEVEL) rx_push <= 1'b1;
                  else RX_FRAME_ERR <= 1'b1;
                  rx_state <= HSU_RX_IDLE;
               end
            end
         endcase
      end
   end

   // A full receive FIFO drops the byte; the host has no flow control line.
   always_ff @(posedge CLK) begin
      if (RST) RX_OVERRUN <= 1'b0;
      else if (CE) RX_OVERRUN <= rx_push && !rx_fifo_ready;
   end

   hsu_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .in_valid(rx_push),
      .in_ready(rx_fifo_ready),
      .in_data(rx_shift),
      .out_valid(RX_VALID),
      .out_ready(RX_READY),
      .out_data(RX_DATA)
   );

   // Transmit path; it runs independently of the receiver.
   hsu_tx_e tx_state;
   logic [CW-1:0] tx_cnt;
   logic [2:0] tx_bit;
   logic [7:0] tx_shift;
   logic tx_have;
   logic tx_pop;
   logic [7:0] tx_head;

   hsu_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .in_valid(TX_VALID),
      .in_ready(TX_READY),
      .in_data(TX_DATA),
      .out_valid(tx_have),
      .out_ready(tx_pop),
      .out_data(tx_head)
   );

   assign tx_pop = (tx_state == HSU_TX_IDLE);

   always_ff @(posedge CLK) begin
      if (RST) begin
         tx_state <= HSU_TX_IDLE;
         tx_cnt <= '0;
         tx_bit <= '0;
         tx_shift <= '0;
         SER_TX <= LINE_IDLE;
      end else if (CE) begin
         if (tx_cnt != '0) tx_cnt <= tx_cnt - 1'b1;
         unique case (tx_state)
            HSU_TX_IDLE: begin
               SER_TX <= LINE_IDLE;
               if (tx_have) begin
                  tx_shift <= tx_head;
                  SER_TX <= START_LEVEL;
                  tx_cnt <= CW'(BIT_CYC - 1);
                  tx_state <= HSU_TX_START;
               end
            end
            HSU_TX_START: begin
               if (tx_cnt == '0) begin
                  SER_TX <= tx_shift[0];
                  tx_shift <= {1'b0, tx_shift[7:1]};
                  tx_bit <= '0;
                  tx_cnt <= CW'(BIT_CYC - 1);
                  tx_state <= HSU_TX_DATA;
               end
            end
            HSU_TX_DATA: begin
               if (tx_cnt == '0) begin
                  tx_cnt <= CW'(BIT_CYC - 1);
                  tx_bit <= tx_bit + 1'b1;
                  if (tx_bit == 3'(DATA_BITS - 1)) begin
                     SER_TX <= STOP_LEVEL;
                     tx_state <= HSU_TX_STOP;
                  end else begin
                     SER_TX <= tx_shift[0];
                     tx_shift <= {1'b0, tx_shift[7:1]};
                  end
               end
            end
            HSU_TX_STOP: begin
               if (tx_cnt == '0) tx_state <= HSU_TX_IDLE;
            end
         endcase
      end
   end

   // Assertions.
   a_rx_start_edge: assert property (@(posedge CLK) disable iff (RST)
      (CE && rx_state == HSU_RX_IDLE && !(rx_prev && !rx_sync)) |=> rx_state == HSU_RX_IDLE)
      else $error("receiver left idle without a falling edge");
   a_rx_false_start: assert property (@(posedge CLK) disable iff (RST)
      (CE && rx_state == HSU_RX_START && rx_tick && rx_sync) |=> rx_state == HSU_RX_IDLE)
      else $error("false start bit not rejected");
   a_rx_valid_start: assert property (@(posedge CLK) disable iff (RST)
      (CE && rx_state == HSU_RX_START && rx_tick && !rx_sync) |=>
      (rx_state == HSU_RX_DATA && rx_cnt == CW'(BIT_CYC - 1)))
      else $error("valid start bit did not begin data capture");
   a_rx_half_bit: assert property (@(posedge CLK) disable iff (RST)
      (CE && rx_state == HSU_RX_IDLE && rx_prev && !rx_sync) |=> rx_cnt == CW'(BIT_CYC / 2 - 1))
      else $error("first sample not half a bit after edge");
   a_rx_bit_period: assert property (@(posedge CLK) disable iff (RST || !CE)
      (rx_state == HSU_RX_DATA && rx_tick) |=> rx_cnt == CW'(BIT_CYC - 1))
      else $error("receive bit period wrong");
   a_tx_bit_hold: assert property (@(posedge CLK) disable iff (RST || !CE)
      (tx_state != HSU_TX_IDLE && tx_cnt != '0) |=> $stable(SER_TX))
      else $error("transmit line changed inside a bit");
   a_tx_start_low: assert property (@(posedge CLK) disable iff (RST || !CE)
      (tx_state == HSU_TX_START) |-> SER_TX == START_LEVEL)
      else $error("start bit not low");
   a_tx_stop_high: assert property (@(posedge CLK) disable iff (RST || !CE)
      (tx_state == HSU_TX_STOP || tx_state == HSU_TX_IDLE) |-> SER_TX == STOP_LEVEL)
      else $error("stop or idle not high");
   a_tx_period: assert property (@(posedge CLK) disable iff (RST || !CE)
      (tx_state == HSU_TX_DATA && tx_cnt == '0) |=> tx_cnt == CW'(BIT_CYC - 1))
      else $error("transmit bit period wrong");
endmodule
`default_nettype wire

// ===== tb/host_serial_uart_test.sv
// Self-checking bench for the host serial port against a host model.
// Assumes a shortened bit of 8 cycles; clock enable drops only in its own scenario.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module host_serial_uart_test;
   logic CLK = 0, RST = 1, CE = 1, SER_RX, SER_TX, TX_VALID = 0, TX_READY;
   logic RX_VALID, RX_READY = 0, RX_OVERRUN, RX_FRAME_ERR;
   logic [7:0] TX_DATA = 8'h00, RX_DATA;
   int error_cnt = 0, cmp_count = 0, ovr = 0, ferr = 0, n;
   hsu_uart #(.BIT_CYC(8), .DEPTH(16)) hsu_uart_i (.CLK(CLK), .RST(RST), .CE(CE),
      .SER_RX(SER_RX), .SER_TX(SER_TX), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
      .TX_DATA(TX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_DATA(RX_DATA),
      .RX_OVERRUN(RX_OVERRUN), .RX_FRAME_ERR(RX_FRAME_ERR));
   hsu_host_model #(.BIT(8)) hsu_host_model_i (.clk(CLK), .line_in(SER_TX), .line_out(SER_RX));
   always #25 CLK = ~CLK;
   // Pulses are counted on the falling edge, away from the edge that updates them.
   always @(negedge CLK) begin
      if (RX_OVERRUN === 1'b1) ovr++;
      if (RX_FRAME_ERR === 1'b1) ferr++;
   end
   task automatic put(input logic [7:0] d);
      @(posedge CLK);
      #1 TX_VALID = 1;
      TX_DATA = d;
      while (TX_READY !== 1'b1) begin @(posedge CLK); #1; end
      @(posedge CLK);
      #1 TX_VALID = 0;
   endtask
   task automatic pop(input logic [7:0] e);
      int k;
      k = 0;
      @(posedge CLK);
      #1;
      while (RX_VALID !== 1'b1 && k < 2000) begin @(posedge CLK); #1; k++; end
      if (k >= 2000) error_cnt++;
      `CHK(RX_DATA, e)
      RX_READY = 1;
      @(posedge CLK);
      #1 RX_READY = 0;
   endtask
   task automatic wq(input int m);
      int k;
      k = 0;
      while (hsu_host_model_i.q.size() < m && k < 3000) begin @(posedge CLK); k++; end
      if (k >= 3000) error_cnt++;
      #1;
   endtask
   task automatic t_duplex;
      fork
         begin hsu_host_model_i.send(8'h5A, 1); hsu_host_model_i.send(8'hC3, 1); end
         begin put(8'hA5); put(8'h3C); end
      join
      pop(8'h5A);
      pop(8'hC3);
      wq(2);
      `CHK(hsu_host_model_i.q[0], 8'hA5)
      `CHK(hsu_host_model_i.q[1], 8'h3C)
      `CHK(SER_TX, 1'b1)
      hsu_host_model_i.q.delete();
      $display("t_duplex done");
   endtask
   task automatic t_false_start;
      // A low pulse shorter than half a bit must not become a character.
      @(posedge CLK);
      #1 hsu_host_model_i.line_out = 1'b0;
      repeat (2) @(posedge CLK);
      #1 hsu_host_model_i.line_out = 1'b1;
      // Waiting longer than a whole frame lets a receiver that kept going show a byte.
      repeat (100) @(posedge CLK);
      #1;
      `CHK(RX_VALID, 1'b0)
      `CHK(ferr, 0)
      hsu_host_model_i.send(8'h81, 1);
      pop(8'h81);
      $display("t_false_start done");
   endtask
   task automatic t_frame_err;
      hsu_host_model_i.send(8'h66, 0);
      repeat (20) @(posedge CLK);
      #1;
      `CHK(ferr, 1)
      `CHK(RX_VALID, 1'b0)
      $display("t_frame_err done");
   endtask
   task automatic t_rx_fill;
      for (int i = 0; i < 17; i++) hsu_host_model_i.send(8'(i), 1);
      repeat (10) @(posedge CLK);
      `CHK(ovr, 1)
      for (int i = 0; i < 16; i++) pop(8'(i));
      `CHK(RX_VALID, 1'b0)
      $display("t_rx_fill done");
   endtask
   task automatic t_tx_fill;
      // One byte leaves for the shifter at once, so seventeen are taken before refusal.
      n = 0;
      @(posedge CLK);
      #1 TX_VALID = 1;
      while (TX_READY === 1'b1 && n < 20) begin
         TX_DATA = 8'(n);
         @(posedge CLK);
         #1 n++;
      end
      TX_VALID = 0;
      `CHK(n, 17)
      wq(17);
      for (int i = 0; i < 17; i++) `CHK(hsu_host_model_i.q[i], 8'(i))
      `CHK(hsu_host_model_i.bad, 0)
      $display("t_tx_fill done");
   endtask
   task automatic t_ce_hold;
      // With the enable low nothing may be taken or launched, however long the request stands.
      hsu_host_model_i.q.delete();
      @(posedge CLK);
      #1 CE = 0;
      TX_VALID = 1;
      TX_DATA = 8'h99;
      repeat (12) @(posedge CLK);
      #1;
      `CHK(SER_TX, 1'b1)
      TX_VALID = 0;
      CE = 1;
      repeat (100) @(posedge CLK);
      #1;
      `CHK(hsu_host_model_i.q.size(), 0)
      `CHK(TX_READY, 1'b1)
      $display("t_ce_hold done");
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #500000;
      error_cnt++;
      end_sim();
   end
   initial begin
      repeat (4) @(posedge CLK);
      #1 RST = 0;
      t_duplex();
      t_false_start();
      t_frame_err();
      t_rx_fill();
      t_tx_fill();
      t_ce_hold();
      end_sim();
   end
endmodule
`default_nettype wire

// ===== tb/hsu_host_model.sv
// Behavioural host serial port: an 8N1 sender and a mid-bit sampling receiver.
// Assumes it shares the device clock and is told the bit length in cycles.
`timescale 1ns/1ns
`default_nettype none
module hsu_host_model #(
   parameter int unsigned BIT = 8
) (
   // Clock
   input wire logic clk,
   // Serial lines
   input wire logic line_in,
   output logic line_out
);
   logic [7:0] q[$];
   logic [7:0] b;
   int bad = 0;
   initial line_out = 1'b1;
   // Sampling in mid-bit stands in for a 16x host, so a short device bit stays in margin.
   always begin
      @(negedge line_in);
      repeat (BIT / 2) @(posedge clk);
      if (line_in !== 1'b0) bad++;
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk);
         b[i] = line_in;
      end
      repeat (BIT) @(posedge clk);
      if (line_in !== 1'b1) bad++;
      q.push_back(b);
   end
   task automatic send(input logic [7:0] d, input logic stop);
      logic [9:0] f;
      f = {stop, d, 1'b0};
      @(posedge clk);
      #1;
      for (int i = 0; i < 10; i++) begin
         line_out = f[i];
         repeat (BIT) @(posedge clk);
         #1;
      end
      line_out = 1'b1;
   endtask
endmodule
`default_nettype wire
